// ### rtl/push_button_power_sequencer.sv
// How it works
// RULE1: when on, button low for off debounce pulls shutdown request low
// RULE2: button held 64 ms base plus extension forces supply off
// RULE3: shutdown request stays low at least its minimum width
// RULE4: after minimum width, request follows button, released on release
// RULE5: processor holds power-off command low 30 us at least
// RULE6: power-off command low in normal running drops supply within 30 us
// RULE7: command and button ignored during 512 ms start-up blanking
// RULE8: command still low at blanking end aborts the power-on
// RULE9: button ignored through the whole lock-out after supply drops
// RULE10: with no extension, supply asserts after 32 ms continuous press
// RULE11: turn-on and forced-off holds each get their own extension
// RULE12: supply asserted after valid press; polarity build option, open-drain
// RULE13: forced-off completion releases request and supply together
// RULE14: off press only pulls request low, supply unaffected
// RULE15: processor raises power-off command before blanking ends
// RULE16: processor finishes housekeeping then drives power-off command low
// RULE17: lock-out after supply release lasts 256 ms
// RULE18: button returning high restarts any running debounce
// RULE19: forced-off extension is 16 timer cycles; early release ends request
// RULE20: reset holds supply off until a valid press
// RULE21: inputs synchronised, every interval a parameterised counter
`timescale 1ns/10ps
module push_button_power_sequencer
    import pb_seq_pkg::*;
#(
    parameter int unsigned ON_EXT_CYC      = 0,
    parameter int unsigned PD_EXT_UNIT_CYC = 0,
    parameter bit          ENABLE_ACT_HIGH = 1'b1,
    parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC,
    parameter int unsigned REQ_MIN_CYCLES  = REQ_MIN_CYC,
    parameter int unsigned BLANK_CYCLES    = BLANK_CYC,
    parameter int unsigned LOCKOUT_CYCLES  = LOCKOUT_CYC,
    parameter int unsigned FORCED_REST_CYCLES = FORCED_REST_CYC
) (
    input  wire logic ref_clk,
    input  wire logic rst_b,
    input  wire logic push_button_n,
    input  wire logic power_off_cmd_n,
    output logic      supply_on_out,
    output logic      supply_on_oe,
    output logic      shutdown_request_n,
    output logic      shutdown_request_oe
);

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic       pb_meta_r;
    logic       pb_r;
    logic       kill_meta_r;
    logic       kill_r;

    // reset to high, the idle level, so leaving reset never looks like a press
    // RULE21: two-stage sync
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            pb_meta_r   <= 1'b1;
            pb_r        <= 1'b1;
            kill_meta_r <= 1'b1;
            kill_r      <= 1'b1;
        end else begin
            pb_meta_r   <= push_button_n;
            pb_r        <= pb_meta_r;
            kill_meta_r <= power_off_cmd_n;
            kill_r      <= kill_meta_r;
        end
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    localparam logic [CNT_W-1:0] ON_HOLD   = CNT_W'(DEBOUNCE_CYCLES + ON_EXT_CYC);
    localparam logic [CNT_W-1:0] OFF_DB    = CNT_W'(DEBOUNCE_CYCLES);
    localparam logic [CNT_W-1:0] REQ_MIN   = CNT_W'(REQ_MIN_CYCLES);
    localparam logic [CNT_W-1:0] BLANK     = CNT_W'(BLANK_CYCLES);
    localparam logic [CNT_W-1:0] LOCKOUT   = CNT_W'(LOCKOUT_CYCLES);
    localparam logic [CNT_W-1:0] FORCE_HLD = CNT_W'(FORCED_REST_CYCLES
                                                   + PDT_CYCLES * PD_EXT_UNIT_CYC);
    localparam logic [CNT_W-1:0] CNT_ONE   = CNT_W'(1);

    seq_state_t       state_r;
    seq_state_t       state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic             on_r;
    logic             req_r;
    seq_pins_t        pins_nxt;

    // looks one count ahead, so a limit of n keeps a state exactly n cycles, and a limit of 0 keeps it one cycle
    function automatic logic expired(input logic [CNT_W-1:0] c, input logic [CNT_W-1:0] lim);
        expired = (c + CNT_ONE) >= lim;
    endfunction : expired

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r + CNT_ONE;
        case (state_r)
            ST_OFF: begin
                cnt_nxt = '0;
                if (!pb_r) begin
                    state_nxt = ST_ON_DB;
                end
            end
            // RULE10: turn-on debounce
            ST_ON_DB: begin
                // RULE18: release restarts
                if (pb_r) begin
                    state_nxt = ST_OFF;
                    cnt_nxt   = '0;
                // RULE11: turn-on extension
                end else if (expired(cnt_r, ON_HOLD)) begin
                    state_nxt = ST_BLANK;
                    cnt_nxt   = '0;
                end
            end
            // RULE7: blanking ignores inputs
            ST_BLANK: begin
                if (expired(cnt_r, BLANK)) begin
                    cnt_nxt = '0;
                    // RULE8: abort on low command
                    state_nxt = kill_r ? ST_RUN : ST_LOCKOUT;
                end
            end
            ST_RUN: begin
                // RULE6: command drops supply
                if (!kill_r) begin
                    state_nxt = ST_LOCKOUT;
                    cnt_nxt   = '0;
                // RULE18: off debounce restart
                end else if (pb_r) begin
                    cnt_nxt = '0;
                // RULE1: off press debounce
                end else if (expired(cnt_r, OFF_DB)) begin
                    state_nxt = ST_REQ_MIN;
                    cnt_nxt   = '0;
                end
            end
            // RULE3: minimum request width
            ST_REQ_MIN: begin
                if (!kill_r) begin
                    state_nxt = ST_LOCKOUT;
                    cnt_nxt   = '0;
                end else if (expired(cnt_r, REQ_MIN)) begin
                    state_nxt = pb_r ? ST_RUN : ST_REQ_HLD;
                    cnt_nxt   = '0;
                end
            end
            // RULE4: request tracks button
            ST_REQ_HLD: begin
                if (!kill_r) begin
                    state_nxt = ST_LOCKOUT;
                    cnt_nxt   = '0;
                // RULE19: early release
                end else if (pb_r) begin
                    state_nxt = ST_RUN;
                    cnt_nxt   = '0;
                // RULE2: forced power-down
                end else if (expired(cnt_r, FORCE_HLD)) begin
                    state_nxt = ST_LOCKOUT;
                    cnt_nxt   = '0;
                end
            end
            // RULE9: button ignored
            ST_LOCKOUT: begin
                // RULE17: lock-out length
                if (expired(cnt_r, LOCKOUT)) begin
                    state_nxt = ST_OFF;
                    cnt_nxt   = '0;
                end
            end
            default: begin
                state_nxt = ST_OFF;
                cnt_nxt   = '0;
            end
        endcase
    end

    // RULE20: reset to off
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state_r <= ST_OFF;
            cnt_r   <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // ----------------------------------------
    // output flops
    // ----------------------------------------
    // decoded from next state so pins move on the same edge as the state
    // RULE14: request does not touch supply
    assign on_r  = (state_nxt == ST_BLANK) || (state_nxt == ST_RUN)
                || (state_nxt == ST_REQ_MIN) || (state_nxt == ST_REQ_HLD);
    assign req_r = (state_nxt == ST_REQ_MIN) || (state_nxt == ST_REQ_HLD);

    // RULE12: polarity option, open drain
    always_comb begin
        pins_nxt.supply_on_out       = 1'b0;
        pins_nxt.supply_on_oe        = ENABLE_ACT_HIGH ? !on_r : on_r;
        pins_nxt.shutdown_request_n  = 1'b0;
        pins_nxt.shutdown_request_oe = req_r;
    end

    // RULE13: release both together
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            supply_on_out       <= 1'b0;
            supply_on_oe        <= ENABLE_ACT_HIGH;
            shutdown_request_n  <= 1'b0;
            shutdown_request_oe <= 1'b0;
        end else begin
            supply_on_out       <= pins_nxt.supply_on_out;
            supply_on_oe        <= pins_nxt.supply_on_oe;
            shutdown_request_n  <= pins_nxt.shutdown_request_n;
            shutdown_request_oe <= pins_nxt.shutdown_request_oe;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic on_now;
    assign on_now = (state_r == ST_BLANK) || (state_r == ST_RUN)
                 || (state_r == ST_REQ_MIN) || (state_r == ST_REQ_HLD);

    kill_drop_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE6
        (state_r == ST_RUN && !kill_r) |=> (state_r == ST_LOCKOUT))
        else $error("command low did not drop supply");
    req_track_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE4
        (state_r == ST_REQ_HLD && pb_r && kill_r) |=> (state_r == ST_RUN))
        else $error("request did not end on release");
    blank_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE7
        (state_r == ST_BLANK && !expired(cnt_r, BLANK)) |=> (state_r == ST_BLANK))
        else $error("blanking left early");
    abort_on_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE8
        (state_r == ST_BLANK && expired(cnt_r, BLANK) && !kill_r)
        |=> (state_r == ST_LOCKOUT))
        else $error("power-on not aborted");
    lockout_ign_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE9
        (state_r == ST_LOCKOUT && !expired(cnt_r, LOCKOUT)) |=> (state_r == ST_LOCKOUT))
        else $error("lock-out left early");
    debounce_rst_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE18
        (state_r == ST_ON_DB && pb_r) |=> (state_r == ST_OFF))
        else $error("debounce not restarted");
    req_min_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE3
        (state_r == ST_REQ_MIN && kill_r && !expired(cnt_r, REQ_MIN))
        |=> (state_r == ST_REQ_MIN))
        else $error("request shorter than minimum");
    both_rel_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE13
        (state_r == ST_REQ_HLD && !pb_r && kill_r && expired(cnt_r, FORCE_HLD))
        |=> (!shutdown_request_oe && (supply_on_oe == ENABLE_ACT_HIGH)))
        else $error("forced off did not release both");
    on_pin_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE12
        supply_on_oe == (on_now ? !ENABLE_ACT_HIGH : ENABLE_ACT_HIGH))
        else $error("supply pin disagrees with state");

    // ----------------------------------------
    // pin and transition checks
    // ----------------------------------------
    logic req_now;
    assign req_now = (state_r == ST_REQ_MIN) || (state_r == ST_REQ_HLD);

    // RULE14: request pin follows state
    req_pin_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE14
        shutdown_request_oe == req_now)
        else $error("request pin disagrees with state");
    // RULE12: open-drain data low
    data_low_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE12
        !supply_on_out && !shutdown_request_n)
        else $error("open-drain data not low");
    // RULE10: turn-on after hold
    on_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE10
        (state_r == ST_ON_DB && !pb_r && expired(cnt_r, ON_HOLD))
        |=> (state_r == ST_BLANK && supply_on_oe == !ENABLE_ACT_HIGH))
        else $error("supply not on after hold");
    // RULE1: request after debounce
    off_db_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE1
        (state_r == ST_RUN && kill_r && !pb_r && expired(cnt_r, OFF_DB))
        |=> shutdown_request_oe)
        else $error("request not raised after debounce");
    // RULE14: request keeps supply
    req_supply_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE14
        (state_r == ST_REQ_MIN && kill_r) |=> (supply_on_oe == !ENABLE_ACT_HIGH))
        else $error("request changed supply");
    // RULE2: forced power-down
    forced_off_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE2
        (state_r == ST_REQ_HLD && kill_r && !pb_r && expired(cnt_r, FORCE_HLD))
        |=> (state_r == ST_LOCKOUT))
        else $error("forced off not taken");
    // RULE6: command during request
    req_kill_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE6
        (req_now && !kill_r) |=> (state_r == ST_LOCKOUT && supply_on_oe == ENABLE_ACT_HIGH))
        else $error("command low ignored during request");
    // RULE9: supply off in lock-out
    lock_off_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE9
        (state_r == ST_LOCKOUT) |-> (supply_on_oe == ENABLE_ACT_HIGH))
        else $error("supply on during lock-out");
    // RULE17: lock-out end
    lockout_end_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE17
        (state_r == ST_LOCKOUT && expired(cnt_r, LOCKOUT)) |=> (state_r == ST_OFF))
        else $error("lock-out did not end");
    // RULE18: off debounce restart
    off_restart_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE18
        (state_r == ST_RUN && kill_r && pb_r) |=> (cnt_r == '0))
        else $error("off debounce not restarted");
    // RULE20: reset holds off
    rst_off_a: assert property (@(posedge ref_clk) // RULE20
        !rst_b |=> (state_r == ST_OFF && supply_on_oe == ENABLE_ACT_HIGH && !shutdown_request_oe))
        else $error("reset did not force off");

endmodule : push_button_power_sequencer

// ### shared/pb_seq_pkg.sv
package pb_seq_pkg;

    // ----------------------------------------
    // timing figures in their printed units
    // ----------------------------------------
    localparam int unsigned CLK_HZ             = 200_000_000;
    localparam int unsigned DEBOUNCE_MS        = 32;
    localparam int unsigned FORCED_OFF_BASE_MS = 64;
    localparam int unsigned REQ_MIN_MS         = 32;
    localparam int unsigned BLANK_MS           = 512;
    localparam int unsigned LOCKOUT_MS         = 256;
    localparam int unsigned KILL_DELAY_US      = 30;
    localparam int unsigned PDT_CYCLES         = 16;

    // ----------------------------------------
    // derived cycle counts
    // ----------------------------------------
    localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
    localparam int unsigned DEBOUNCE_CYC  = DEBOUNCE_MS * CYC_PER_MS;
    localparam int unsigned REQ_MIN_CYC   = REQ_MIN_MS * CYC_PER_MS;
    localparam int unsigned BLANK_CYC     = BLANK_MS * CYC_PER_MS;
    localparam int unsigned LOCKOUT_CYC   = LOCKOUT_MS * CYC_PER_MS;
    // the forced-off hold runs past the request window for the rest of the base time
    localparam int unsigned FORCED_REST_CYC = (FORCED_OFF_BASE_MS - DEBOUNCE_MS - REQ_MIN_MS)
                                              * CYC_PER_MS;
    localparam int unsigned KILL_DELAY_CYC = (KILL_DELAY_US * CYC_PER_MS) / 1000;

    localparam int unsigned CNT_W = 32;

    typedef enum logic [2:0] {
        ST_OFF     = 3'b000,
        ST_ON_DB   = 3'b001,
        ST_BLANK   = 3'b010,
        ST_RUN     = 3'b011,
        ST_REQ_MIN = 3'b100,
        ST_REQ_HLD = 3'b101,
        ST_LOCKOUT = 3'b110
    } seq_state_t;

    typedef struct packed {
        logic supply_on_out;
        logic supply_on_oe;
        logic shutdown_request_n;
        logic shutdown_request_oe;
    } seq_pins_t;

endpackage : pb_seq_pkg

// ### test/processor_model.sv
`timescale 1ns/10ps
module processor_model
    import pb_seq_pkg::*;
#(
    parameter int unsigned BOOT_CYC  = 8,
    parameter int unsigned HOUSE_CYC = 6
) (
    input  wire logic ref_clk,
    input  wire logic powered,
    input  wire logic request,
    input  wire logic hang,
    input  wire logic obey,
    output logic      power_off_cmd_n
);
    int unsigned cnt_r    = 0;
    logic        booted_r = 1'b0;
    logic        kill_r   = 1'b0;
    // ----------------------------------------
    // boot and shutdown handshake
    // ----------------------------------------
    always_ff @(negedge ref_clk) begin
        if (!powered) begin
            cnt_r    <= 0;
            booted_r <= 1'b0;
            kill_r   <= 1'b0;
        end else if (!booted_r) begin
            cnt_r <= cnt_r + 1;
            if (cnt_r == BOOT_CYC && !hang) begin
                booted_r <= 1'b1;
                cnt_r    <= 0;
            end
        end else if (!kill_r) begin
            cnt_r  <= (request && obey) ? cnt_r + 1 : 0;
            kill_r <= request && obey && cnt_r == HOUSE_CYC;
        end
    end
    // kill held, then unpowered line stays low
    assign power_off_cmd_n = booted_r && !kill_r;
endmodule : processor_model

// ### test/push_button_power_sequencer_bench.sv
`timescale 1ns/10ps
module push_button_power_sequencer_bench;
    import pb_seq_pkg::*;
    localparam int DB = 10, EXT = 3, REQ = 10, BLK = 20, LOCK = 40, REST = 5, PDU = 1;
    logic ref_clk = 0, rst_b = 0, push_button_n = 1, hang = 0, obey = 0;
    logic power_off_cmd_n, supply_on_out, supply_on_oe, shutdown_request_n, shutdown_request_oe;
    logic on_w, req_w, oe_inv;
    int   err_total = 0, n_checks = 0, n, req_cyc = 0, req_base = 0;
    // polarity option 1: released enable means supply on
    assign on_w  = (supply_on_oe === 1'b0);
    assign req_w = (shutdown_request_oe === 1'b1);
    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) req_cyc <= req_cyc + int'(req_w);
    push_button_power_sequencer #(.ON_EXT_CYC(EXT), .PD_EXT_UNIT_CYC(PDU),
        .ENABLE_ACT_HIGH(1'b1), .DEBOUNCE_CYCLES(DB), .REQ_MIN_CYCLES(REQ),
        .BLANK_CYCLES(BLK), .LOCKOUT_CYCLES(LOCK), .FORCED_REST_CYCLES(REST)) dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .push_button_n(push_button_n),
        .power_off_cmd_n(power_off_cmd_n), .supply_on_out(supply_on_out),
        .supply_on_oe(supply_on_oe), .shutdown_request_n(shutdown_request_n),
        .shutdown_request_oe(shutdown_request_oe));
    // second copy with the other polarity must drive the inverse of the first copy's supply enable
    push_button_power_sequencer #(.ON_EXT_CYC(EXT), .PD_EXT_UNIT_CYC(PDU),
        .ENABLE_ACT_HIGH(1'b0), .DEBOUNCE_CYCLES(DB), .REQ_MIN_CYCLES(REQ),
        .BLANK_CYCLES(BLK), .LOCKOUT_CYCLES(LOCK), .FORCED_REST_CYCLES(REST)) dut_inv (
        .ref_clk(ref_clk), .rst_b(rst_b), .push_button_n(push_button_n),
        .power_off_cmd_n(power_off_cmd_n), .supply_on_out(),
        .supply_on_oe(oe_inv), .shutdown_request_n(),
        .shutdown_request_oe());
    processor_model cpu (.ref_clk(ref_clk), .powered(on_w), .request(req_w), .hang(hang),
        .obey(obey), .power_off_cmd_n(power_off_cmd_n));
    // ----------------------------------------
    // expectations and helpers
    // ----------------------------------------
    function automatic int exp_on();
        return DB + EXT;
    endfunction : exp_on
    function automatic int exp_forced();
        return DB + REQ + REST + 16 * PDU;
    endfunction : exp_forced
    task automatic end_of_test();
        if (err_total == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test
    task automatic tick(input int c);
        repeat (c) begin
            @(negedge ref_clk);
            if (rst_b) chk("supply_oe_inverse", !supply_on_oe, oe_inv);
        end
    endtask : tick
    task automatic chk(input string nm, input logic e, input logic g);
        n_checks++;
        if (e !== g) begin
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
            err_total++;
        end
    endtask : chk
    task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
        n_checks++;
        if (g < lo || g > hi) begin
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, g);
            err_total++;
        end
    endtask : chk_rng
    // bounded wait: sel 0 supply, 1 request, 2 command line
    task automatic wait_until(input int sel, input logic v, input int lim, output int c);
        c = 0;
        while ((sel == 0 ? on_w : sel == 1 ? req_w : power_off_cmd_n) !== v) begin
            if (c >= lim) begin
                $display("CHECK FAILED wait_%0d expected %b seen timeout", sel, v);
                err_total++;
                end_of_test();
            end
            tick(1);
            c++;
        end
    endtask : wait_until
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'hE1CA));
        tick(4);
        chk("supply_oe_rst", 1'b1, supply_on_oe);
        chk("req_oe_rst", 1'b0, shutdown_request_oe);
        rst_b = 1'b1;
        // short presses add up past the hold but never meet it in one piece
        repeat (6) begin
            push_button_n = 1'b0;
            tick($urandom_range(DB - 3, 1));
            push_button_n = 1'b1;
            tick($urandom_range(3, 1));
        end
        tick(8);
        chk("on_after_glitch", 1'b0, on_w);
        push_button_n = 1'b0;
        wait_until(0, 1'b1, 40, n);
        push_button_n = 1'b1;
        chk_rng("on_delay", exp_on(), exp_on() + 6, n);
        req_base = req_cyc;
        tick(2);
        push_button_n = 1'b0;
        tick(DB + 4);
        push_button_n = 1'b1;
        chk("req_in_blank", 1'b0, req_cyc != req_base);
        chk("on_in_blank", 1'b1, on_w);
        tick(BLK);
        push_button_n = 1'b0;
        wait_until(1, 1'b1, 40, n);
        push_button_n = 1'b1;
        chk_rng("req_delay", DB, DB + 6, n);
        wait_until(1, 1'b0, 40, n);
        chk_rng("req_width", REQ, REQ + 6, n);
        chk("on_after_req", 1'b1, on_w);
        tick(4);
        push_button_n = 1'b0;
        wait_until(1, 1'b1, 40, n);
        tick(REQ + 8);
        chk("req_held", 1'b1, req_w);
        chk("supply_data", 1'b0, supply_on_out);
        chk("req_data", 1'b0, shutdown_request_n);
        push_button_n = 1'b1;
        wait_until(1, 1'b0, 8, n);
        chk("on_early_release", 1'b1, on_w);
        obey = 1'b1;
        tick(4);
        push_button_n = 1'b0;
        wait_until(1, 1'b1, 40, n);
        push_button_n = 1'b1;
        wait_until(2, 1'b0, 100, n);
        wait_until(0, 1'b0, KILL_DELAY_CYC, n);
        push_button_n = 1'b0;
        tick(LOCK - 8);
        push_button_n = 1'b1;
        tick(2);
        chk("on_in_lockout", 1'b0, on_w);
        tick(10);
        hang = 1'b1;
        obey = 1'b0;
        push_button_n = 1'b0;
        wait_until(0, 1'b1, 40, n);
        push_button_n = 1'b1;
        chk_rng("on_after_lockout", exp_on(), exp_on() + 6, n);
        wait_until(0, 1'b0, BLK + 8, n);
        chk_rng("abort_time", BLK, BLK + 6, n);
        tick(LOCK + 4);
        hang = 1'b0;
        push_button_n = 1'b0;
        wait_until(0, 1'b1, 40, n);
        push_button_n = 1'b1;
        tick(BLK + 4);
        req_base = req_cyc;
        push_button_n = 1'b0;
        wait_until(0, 1'b0, exp_forced() + 10, n);
        chk_rng("forced_time", exp_forced(), exp_forced() + 6, n);
        chk("req_at_forced", 1'b0, req_w);
        chk("req_before_forced", 1'b1, req_cyc != req_base);
        push_button_n = 1'b1;
        tick(LOCK + 4);
        end_of_test();
    end
endmodule : push_button_power_sequencer_bench
